// ### mailbox_pkg.sv
// Shared constants and types for the slave port mailbox
package mailbox_pkg;
    // Internal I/O map seen by the slave processor
    localparam logic [7:0] ADDR_DATA_ZERO    = 8'h20;
    localparam logic [7:0] ADDR_DATA_ONE     = 8'h21;
    localparam logic [7:0] ADDR_DATA_TWO     = 8'h22;
    localparam logic [7:0] ADDR_FULL_FLAGS   = 8'h23;
    localparam logic [7:0] ADDR_PORT_CONTROL = 8'h24;
    // Master side selects on the two port address lines
    localparam logic [1:0] PORT_SEL_ZERO  = 2'h0;
    localparam logic [1:0] PORT_SEL_ONE   = 2'h1;
    localparam logic [1:0] PORT_SEL_TWO   = 2'h2;
    localparam logic [1:0] PORT_SEL_FLAGS = 2'h3;
    // Full flag positions
    localparam int FLAG_IN_IRQ    = 7;
    localparam int FLAG_IN_TWO    = 6;
    localparam int FLAG_IN_ONE    = 5;
    localparam int FLAG_IN_ZERO   = 4;
    localparam int FLAG_OUT_ATTN  = 3;
    localparam int FLAG_OUT_TWO   = 2;
    localparam int FLAG_OUT_ONE   = 1;
    localparam int FLAG_OUT_ZERO  = 0;
    // Control field positions
    localparam int CTRL_IGNORE_BOOT = 7;
    localparam int CTRL_PIN_HIGH    = 6;
    localparam int CTRL_PIN_LOW     = 5;
    localparam int CTRL_PORT_ENABLE = 3;
    localparam int CTRL_PORT_A_OUT  = 2;
    // Reset values and encodings
    localparam logic [7:0] FLAGS_RESET   = 8'h00;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;
    localparam logic [1:0] PRIO_DISABLED = 2'h0;
    localparam logic [1:0] BOOT_STRAP    = 2'h1;
    localparam logic [1:0] BOOT_RELEASE  = 2'h0;
    // Cycles after reset release before the strap is trusted
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    // Sampled master pins travel together
    typedef struct packed {
        logic       select_n;
        logic       read_n;
        logic       write_n;
        logic [1:0] addr;
        logic [7:0] data;
    } master_pins_type;
    // Boot sequencing
    typedef enum logic [1:0] {
        ST_STRAP = 2'b00,
        ST_BOOT  = 2'b01,
        ST_RUN   = 2'b10
    } boot_state_type;
endpackage

// ### slave_port_mailbox.sv
// Slave port mailbox: two-way byte mailboxes, flags, control and boot
//
// Function
// - Separate inbound and outbound register per mailbox
// - Slave map: mailboxes 0x20-0x22, flags, control
// - Master selects mailboxes and flags by address
// - Reads change each bit once, no wavering
// - Control bit 7 ignores boot pins
// - Strap 01 at reset suspends execution
// - Pins 00 ends boot, start at zero
// - Control bits 6,5 read boot pins
// - Control bit 3 enables slave port
// - Cold boot sets slave port enable
// - Bit 2 sets port A direction
// - Bits 1,0 give interrupt priority
// - Bit 7 set by master, slave clears
// - Inbound full flags clear on slave read
// - Bit 3 set by slave, master clears
// - Outbound full flags clear on master read
// - Mailbox 0 flags drive irq and attention
// - Attention low on slave mailbox 0 write, high on master flags write
// - Drive data only during select and read
// - Master write latched at strobe end
// - Master write to mailbox 0 sets interrupt flip-flop
`timescale 1ns/10ps
module slave_port_mailbox
    import mailbox_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       ARST_N,
    input  wire logic [7:0] IO_ADDR,
    input  wire logic [7:0] IO_WDATA,
    input  wire logic       IO_WR,
    input  wire logic       IO_RD,
    output logic      [7:0] IO_RDATA,
    input  wire logic [1:0] PORT_ADDR,
    input  wire logic       PORT_SELECT_N,
    input  wire logic       PORT_READ_STROBE_N,
    input  wire logic       PORT_WRITE_STROBE_N,
    input  wire logic [7:0] PORT_DATA_IN,
    output logic      [7:0] PORT_DATA_OUT,
    output logic            PORT_DATA_OE,
    output logic            MASTER_ATTENTION_N,
    input  wire logic       BOOT_MODE_PIN_LOW,
    input  wire logic       BOOT_MODE_PIN_HIGH,
    output logic      [1:0] SLAVE_IRQ_LEVEL,
    output logic            SLAVE_PORT_ENABLE,
    output logic            PORT_A_OUTPUT,
    output logic            COLD_BOOT_HOLD,
    output logic            START_AT_ZERO
);

    logic            rst_meta;
    logic            rst_n;
    master_pins_type pin_s1;
    master_pins_type pin_s2;
    master_pins_type pin_s3;
    master_pins_type pins;
    logic [1:0]      boot_s1;
    logic [1:0]      boot_s2;
    logic [1:0]      boot_s3;
    logic [1:0]      boot_pins;
    logic            wr_active;
    logic            rd_active;
    logic            wr_active_q;
    logic            rd_active_q;
    logic            master_wr_done;
    logic            master_rd_done;
    logic [1:0]      wr_addr;
    logic [7:0]      wr_data;
    logic [1:0]      rd_addr;
    logic [7:0]      in_box [3];
    logic [7:0]      out_box [3];
    logic [7:0]      flags;
    logic [7:0]      next_flags;
    logic            ignore_boot;
    logic            port_enable;
    logic            port_a_out;
    logic [1:0]      irq_prio;
    boot_state_type  boot_state;
    logic [1:0]      strap_count;
    logic            slave_wr;
    logic            slave_rd;
    logic [1:0]      slave_box;
    logic            slave_box_hit;

    // Mailbox index for a slave address inside the data window
    function automatic logic [1:0] box_index(input logic [7:0] addr);
        box_index = addr[1:0] - ADDR_DATA_ZERO[1:0];
    endfunction

    // Master byte for a port address; flags when address is three
    function automatic logic [7:0] master_view(
        input logic [1:0] sel,
        input logic [7:0] b0,
        input logic [7:0] b1,
        input logic [7:0] b2,
        input logic [7:0] st
    );
        unique case (sel)
            PORT_SEL_ZERO: master_view = b0;
            PORT_SEL_ONE:  master_view = b1;
            PORT_SEL_TWO:  master_view = b2;
            PORT_SEL_FLAGS: master_view = st;
        endcase
    endfunction

    // Reset release through two flops, assertion stays asynchronous
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Master pins are asynchronous: three stages, accept on agreement
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= '1;
            pin_s2 <= '1;
            pin_s3 <= '1;
            pins   <= '1;
        end else begin
            pin_s1 <= {PORT_SELECT_N, PORT_READ_STROBE_N,
                       PORT_WRITE_STROBE_N, PORT_ADDR, PORT_DATA_IN};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            // Per-bit agreement, so a noisy data bus cannot stall strobes
            pins <= (pin_s3 & ~(pin_s2 ^ pin_s3)) |
                    (pins & (pin_s2 ^ pin_s3));
        end
    end

    // Boot pins get three stages too, but are accepted only when both bits agree
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            boot_s1   <= 2'h0;
            boot_s2   <= 2'h0;
            boot_s3   <= 2'h0;
            boot_pins <= 2'h0;
        end else begin
            boot_s1 <= {BOOT_MODE_PIN_HIGH, BOOT_MODE_PIN_LOW};
            boot_s2 <= boot_s1;
            boot_s3 <= boot_s2;
            if (boot_s2 == boot_s3) begin
                boot_pins <= boot_s3;
            end
        end
    end

    // Strobe qualification by select; either rising ends the access
    assign wr_active      = !pins.select_n && !pins.write_n;
    assign rd_active      = !pins.select_n && !pins.read_n;
    assign master_wr_done = wr_active_q && !wr_active;
    assign master_rd_done = rd_active_q && !rd_active;

    // Address and data follow the pins while the write strobe is low, then hold
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_active_q <= 1'b0;
            rd_active_q <= 1'b0;
            wr_addr     <= PORT_SEL_ZERO;
            wr_data     <= BYTE_ZERO;
            rd_addr     <= PORT_SEL_ZERO;
        end else begin
            wr_active_q <= wr_active;
            rd_active_q <= rd_active;
            if (wr_active) begin
                wr_addr <= pins.addr;
                wr_data <= pins.data;
            end
            if (rd_active) begin
                rd_addr <= pins.addr;
            end
        end
    end

    // Slave side decode, same clock so no synchroniser
    assign slave_wr      = IO_WR;
    assign slave_rd      = IO_RD;
    assign slave_box     = box_index(IO_ADDR);
    assign slave_box_hit = (IO_ADDR >= ADDR_DATA_ZERO) &&
                           (IO_ADDR <= ADDR_DATA_TWO);

    // Inbound boxes written only by the master, read only by the slave
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            in_box[0] <= BYTE_ZERO;
            in_box[1] <= BYTE_ZERO;
            in_box[2] <= BYTE_ZERO;
        end else if (master_wr_done && wr_addr != PORT_SEL_FLAGS) begin
            in_box[wr_addr] <= wr_data;
        end
    end

    // Outbound boxes written only by the slave, read only by the master
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            out_box[0] <= BYTE_ZERO;
            out_box[1] <= BYTE_ZERO;
            out_box[2] <= BYTE_ZERO;
        end else if (slave_wr && slave_box_hit) begin
            out_box[slave_box] <= IO_WDATA;
        end
    end

    // Flags: clears first, sets last so a same-cycle event survives
    always_comb begin
        next_flags = flags;
        if (slave_wr && IO_ADDR == ADDR_FULL_FLAGS) begin
            next_flags[FLAG_IN_IRQ] = 1'b0;
        end
        if (slave_rd && slave_box_hit) begin
            next_flags[FLAG_IN_ZERO + int'(slave_box)] = 1'b0;
        end
        if (master_wr_done && wr_addr == PORT_SEL_FLAGS) begin
            next_flags[FLAG_OUT_ATTN] = 1'b0;
        end
        if (master_rd_done && rd_addr != PORT_SEL_FLAGS) begin
            next_flags[FLAG_OUT_ZERO + int'(rd_addr)] = 1'b0;
        end
        if (master_wr_done && wr_addr != PORT_SEL_FLAGS) begin
            next_flags[FLAG_IN_ZERO + int'(wr_addr)] = 1'b1;
            if (wr_addr == PORT_SEL_ZERO) begin
                next_flags[FLAG_IN_IRQ] = 1'b1;
            end
        end
        if (slave_wr && slave_box_hit) begin
            next_flags[FLAG_OUT_ZERO + int'(slave_box)] = 1'b1;
            if (slave_box == PORT_SEL_ZERO) begin
                next_flags[FLAG_OUT_ATTN] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            flags <= FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // Attention follows the outbound mailbox 0 latch, active low
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            MASTER_ATTENTION_N <= 1'b1;
        end else begin
            MASTER_ATTENTION_N <= !next_flags[FLAG_OUT_ATTN];
        end
    end

    // Interrupt level only while the inbound latch is set and enabled
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            SLAVE_IRQ_LEVEL <= PRIO_DISABLED;
        end else if (next_flags[FLAG_IN_IRQ]) begin
            SLAVE_IRQ_LEVEL <= irq_prio;
        end else begin
            SLAVE_IRQ_LEVEL <= PRIO_DISABLED;
        end
    end

    // Master data bus: registered byte, enable only during a read
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PORT_DATA_OUT <= BYTE_ZERO;
            PORT_DATA_OE  <= 1'b0;
        end else begin
            PORT_DATA_OE  <= rd_active;
            // One flop per bit: each moves once from old to new
            PORT_DATA_OUT <= master_view(pins.addr, out_box[0],
                                         out_box[1], out_box[2],
                                         next_flags);
        end
    end

    // Control writes; cold boot forces the port on
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ignore_boot <= 1'b0;
            port_enable <= 1'b0;
            port_a_out  <= 1'b0;
            irq_prio    <= PRIO_DISABLED;
        end else begin
            if (slave_wr && IO_ADDR == ADDR_PORT_CONTROL) begin
                ignore_boot <= IO_WDATA[CTRL_IGNORE_BOOT];
                port_enable <= IO_WDATA[CTRL_PORT_ENABLE];
                port_a_out  <= IO_WDATA[CTRL_PORT_A_OUT];
                irq_prio    <= IO_WDATA[1:0];
            end
            if (boot_state == ST_BOOT) begin
                port_enable <= 1'b1;
            end
        end
    end

    // Port muxing outputs; direction matters only with the port off
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            SLAVE_PORT_ENABLE <= 1'b0;
            PORT_A_OUTPUT     <= 1'b0;
        end else begin
            SLAVE_PORT_ENABLE <= port_enable;
            PORT_A_OUTPUT     <= !port_enable && port_a_out;
        end
    end

    // Strap read only once the accepted pins match the settled pipeline
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            boot_state     <= ST_STRAP;
            strap_count    <= 2'h0;
            COLD_BOOT_HOLD <= 1'b0;
            START_AT_ZERO  <= 1'b0;
        end else begin
            START_AT_ZERO <= 1'b0;
            unique case (boot_state)
                ST_STRAP: begin
                    strap_count <= strap_count + 2'h1;
                    if (strap_count == STRAP_WAIT &&
                        boot_pins == boot_s3) begin
                        if (!ignore_boot && boot_pins == BOOT_STRAP) begin
                            boot_state     <= ST_BOOT;
                            COLD_BOOT_HOLD <= 1'b1;
                        end else begin
                            boot_state    <= ST_RUN;
                            START_AT_ZERO <= 1'b1;
                        end
                    end
                end
                ST_BOOT: begin
                    if (boot_pins == BOOT_RELEASE) begin
                        boot_state     <= ST_RUN;
                        COLD_BOOT_HOLD <= 1'b0;
                        START_AT_ZERO  <= 1'b1;
                    end
                end
                ST_RUN:  boot_state <= ST_RUN;
                default: boot_state <= ST_RUN;
            endcase
        end
    end

    // Slave read data, one cycle after the strobe; unmapped reads 0
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            IO_RDATA <= BYTE_ZERO;
        end else if (slave_rd) begin
            if (slave_box_hit) begin
                IO_RDATA <= in_box[slave_box];
            end else if (IO_ADDR == ADDR_FULL_FLAGS) begin
                IO_RDATA <= flags;
            end else if (IO_ADDR == ADDR_PORT_CONTROL) begin
                // Write-only fields read back as zero
                IO_RDATA <= BYTE_ZERO;
                IO_RDATA[CTRL_PIN_HIGH] <= boot_pins[1];
                IO_RDATA[CTRL_PIN_LOW]  <= boot_pins[0];
            end else begin
                IO_RDATA <= BYTE_ZERO;
            end
        end else begin
            IO_RDATA <= BYTE_ZERO;
        end
    end
endmodule

// ### slave_port_mailbox_checker.sv
// Port-level assertions for the slave port mailbox
`timescale 1ns/10ps
module slave_port_mailbox_checker
    import mailbox_pkg::*;
(
    input wire logic       CLK,
    input wire logic       ARST_N,
    input wire logic [7:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    input wire logic       IO_WR,
    input wire logic       IO_RD,
    input wire logic [7:0] IO_RDATA,
    input wire logic       PORT_SELECT_N,
    input wire logic       PORT_READ_STROBE_N,
    input wire logic       PORT_DATA_OE,
    input wire logic       MASTER_ATTENTION_N,
    input wire logic [1:0] SLAVE_IRQ_LEVEL,
    input wire logic       SLAVE_PORT_ENABLE,
    input wire logic       PORT_A_OUTPUT,
    input wire logic       COLD_BOOT_HOLD,
    input wire logic       START_AT_ZERO
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    logic [7:0] wdata_d1;
    logic [7:0] wdata_d2;
    // Delayed write byte, so control effects two cycles on can be compared
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wdata_d1 <= 8'h00;
            wdata_d2 <= 8'h00;
        end else begin
            wdata_d1 <= IO_WDATA;
            wdata_d2 <= wdata_d1;
        end
    end
    // Slave accesses that start multi-step behaviour
    sequence s_ctrl_wr;
        IO_WR && IO_ADDR == ADDR_PORT_CONTROL;
    endsequence
    sequence s_flags_wr;
        IO_WR && IO_ADDR == ADDR_FULL_FLAGS;
    endsequence
    a_attn_on_write: assert property (
        IO_WR && IO_ADDR == ADDR_DATA_ZERO |=> !MASTER_ATTENTION_N)
        else $error("attention not raised by mailbox zero write");
    a_rdata_idle: assert property (
        !IO_RD |=> IO_RDATA == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (
        IO_RD && (IO_ADDR < ADDR_DATA_ZERO || IO_ADDR > ADDR_PORT_CONTROL)
        |=> IO_RDATA == 8'h00)
        else $error("unmapped read returned data");
    a_ctrl_wo_bits: assert property (
        IO_RD && IO_ADDR == ADDR_PORT_CONTROL
        |=> IO_RDATA[7] == 1'b0 && IO_RDATA[4:0] == 5'h00)
        else $error("write-only control bits read back");
    a_oe_needs_read: assert property (
        $rose(PORT_DATA_OE) |->
        $past(PORT_SELECT_N, 2) == 1'b0 &&
        $past(PORT_READ_STROBE_N, 2) == 1'b0)
        else $error("data bus driven without select and read");
    a_oe_drops: assert property (
        PORT_SELECT_N [*8] |-> !PORT_DATA_OE)
        else $error("data bus still driven after deselect");
    a_prio_off: assert property (
        s_ctrl_wr ##0 IO_WDATA[1:0] == PRIO_DISABLED
        |-> ##2 SLAVE_IRQ_LEVEL == PRIO_DISABLED)
        else $error("interrupt level nonzero with priority off");
    a_flags_clear_irq: assert property (
        s_flags_wr |-> ##2 SLAVE_IRQ_LEVEL == 2'h0)
        else $error("flags write did not drop interrupt");
    a_enable_follows: assert property (
        s_ctrl_wr ##0 !COLD_BOOT_HOLD |-> ##2
        SLAVE_PORT_ENABLE == wdata_d2[3] &&
        PORT_A_OUTPUT == (!wdata_d2[3] && wdata_d2[2]))
        else $error("enable or direction not from control write");
    a_boot_enable: assert property (
        COLD_BOOT_HOLD [*3] |-> SLAVE_PORT_ENABLE)
        else $error("cold boot without slave port enable");
    a_start_pulse: assert property (
        START_AT_ZERO |=> !START_AT_ZERO && !COLD_BOOT_HOLD)
        else $error("start pulse too long or hold remains");
endmodule
bind slave_port_mailbox slave_port_mailbox_checker chk_u (
    .CLK(CLK), .ARST_N(ARST_N), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA),
    .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_RDATA(IO_RDATA),
    .PORT_SELECT_N(PORT_SELECT_N), .PORT_READ_STROBE_N(PORT_READ_STROBE_N),
    .PORT_DATA_OE(PORT_DATA_OE), .MASTER_ATTENTION_N(MASTER_ATTENTION_N),
    .SLAVE_IRQ_LEVEL(SLAVE_IRQ_LEVEL), .SLAVE_PORT_ENABLE(SLAVE_PORT_ENABLE),
    .PORT_A_OUTPUT(PORT_A_OUTPUT), .COLD_BOOT_HOLD(COLD_BOOT_HOLD),
    .START_AT_ZERO(START_AT_ZERO)
);

// ### master_port_model.sv
// Behavioural external master on the asynchronous port strobes
`timescale 1ns/10ps
module master_port_model (
    input  wire logic       clk,
    input  wire logic [7:0] bus_in,
    input  wire logic       bus_oe,
    output logic      [1:0] addr,
    output logic            select_n,
    output logic            read_n,
    output logic            write_n,
    output logic      [7:0] wdata,
    output logic            drive
);
    // Idle: deselected, strobes high, bus released
    initial begin
        addr = 2'h0;
        select_n = 1'b1;
        read_n = 1'b1;
        write_n = 1'b1;
        wdata = 8'h00;
        drive = 1'b0;
    end
    // Strobes held 8 cycles, since shorter pulses may be missed at 40 MHz
    task automatic write_byte(input logic [1:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        drive = 1'b1;
        select_n = 1'b0;
        write_n = 1'b0;
        repeat (8) @(negedge clk);
        write_n = 1'b1;
        select_n = 1'b1;
        repeat (2) @(negedge clk);
        drive = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    // Read holds select and strobe until the byte is taken
    task automatic read_byte(input logic [1:0] a, output logic [7:0] d,
                             output logic ok);
        int n;
        ok = 1'b0;
        @(negedge clk);
        addr = a;
        select_n = 1'b0;
        read_n = 1'b0;
        for (n = 0; n < 20 && !ok; n++) begin
            @(negedge clk);
            ok = bus_oe;
        end
        repeat (3) @(negedge clk);
        d = bus_in;
        read_n = 1'b1;
        select_n = 1'b1;
        repeat (10) @(negedge clk);
    endtask
endmodule

// ### slave_port_mailbox_bench.sv
// Self-checking bench for the slave port mailbox
`timescale 1ns/10ps
module slave_port_mailbox_bench
    import mailbox_pkg::*;
;
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    logic [7:0] io_addr = 8'h00;
    logic [7:0] io_wdata = 8'h00;
    logic       io_wr = 1'b0;
    logic       io_rd = 1'b0;
    logic       pin_low = 1'b1;
    logic       pin_high = 1'b0;
    logic [7:0] io_rdata, port_data_out, m_wdata, bus_last = 8'h00;
    logic [1:0] m_addr, irq_level;
    logic       m_sel_n, m_rd_n, m_wr_n, m_drive, port_data_oe, attn_n;
    logic       port_enable, port_a_out, boot_hold, start_zero, seen;
    logic [7:0] i;
    int         n, err_total = 0, compares = 0;
    wire  [7:0] port_data_lines = port_data_oe ? port_data_out :
                                  (m_drive ? m_wdata : ~bus_last);
    // Released bus shows a changing pattern, never a stale byte
    always_ff @(posedge clk) bus_last <= port_data_lines;
    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    slave_port_mailbox dut_u (.CLK(clk), .ARST_N(arst_n), .IO_ADDR(io_addr),
        .IO_WDATA(io_wdata), .IO_WR(io_wr), .IO_RD(io_rd), .IO_RDATA(io_rdata),
        .PORT_ADDR(m_addr), .PORT_SELECT_N(m_sel_n),
        .PORT_READ_STROBE_N(m_rd_n),
        .PORT_WRITE_STROBE_N(m_wr_n), .PORT_DATA_IN(port_data_lines),
        .PORT_DATA_OUT(port_data_out), .PORT_DATA_OE(port_data_oe),
        .MASTER_ATTENTION_N(attn_n), .BOOT_MODE_PIN_LOW(pin_low),
        .BOOT_MODE_PIN_HIGH(pin_high), .SLAVE_IRQ_LEVEL(irq_level),
        .SLAVE_PORT_ENABLE(port_enable), .PORT_A_OUTPUT(port_a_out),
        .COLD_BOOT_HOLD(boot_hold), .START_AT_ZERO(start_zero));
    master_port_model m_u (.clk(clk), .bus_in(port_data_lines),
        .bus_oe(port_data_oe), .addr(m_addr), .select_n(m_sel_n),
        .read_n(m_rd_n), .write_n(m_wr_n), .wdata(m_wdata), .drive(m_drive));
    // Verdict and end of run
    task automatic complete_run;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] got,
                         input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Slave bus: one-cycle strobes, data the cycle after a read
    task automatic io_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
    endtask
    task automatic io_read(input logic [7:0] a, input logic [7:0] exp,
                           input string name);
        @(negedge clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        check(name, io_rdata, exp);
    endtask
    task automatic m_read(input logic [1:0] a, input logic [7:0] exp,
                          input string name);
        logic [7:0] d;
        logic       ok;
        m_u.read_byte(a, d, ok);
        check("master read answered", {7'h00, ok}, 8'h01);
        if (!ok) complete_run;
        check(name, d, exp);
    endtask
    // Main sequence; boot strap 01 held through reset
    initial begin
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        for (n = 0; n < 30 && boot_hold !== 1'b1; n++) @(negedge clk);
        check("boot hold", {7'h00, boot_hold}, 8'h01);
        if (boot_hold !== 1'b1) complete_run;
        // Enable follows the hold by two registered stages
        repeat (2) @(negedge clk);
        check("boot enable", {7'h00, port_enable}, 8'h01);
        io_read(ADDR_PORT_CONTROL, 8'h20, "control pins");
        io_write(ADDR_PORT_CONTROL, 8'h00);
        @(negedge clk);
        check("enable kept", {7'h00, port_enable}, 8'h01);
        pin_low = 1'b0;
        seen = 1'b0;
        for (n = 0; n < 30 && !seen; n++) begin
            @(posedge clk);
            #1 seen = (start_zero === 1'b1);
        end
        check("start pulse", {7'h00, seen}, 8'h01);
        if (!seen) complete_run;
        check("hold released", {7'h00, boot_hold}, 8'h00);
        io_write(ADDR_PORT_CONTROL, 8'h88);
        io_read(ADDR_PORT_CONTROL, 8'h00, "control readback");
        $display("test cold boot finished");
        io_write(ADDR_DATA_ZERO, 8'h5a);
        io_write(ADDR_DATA_ONE, 8'ha5);
        io_write(ADDR_DATA_TWO, 8'h3c);
        check("attention", {7'h00, attn_n}, 8'h00);
        io_read(ADDR_FULL_FLAGS, 8'h0f, "outbound flags");
        m_read(PORT_SEL_FLAGS, 8'h0f, "master flags");
        m_read(PORT_SEL_ZERO, 8'h5a, "master box0");
        m_read(PORT_SEL_ONE, 8'ha5, "master box1");
        m_read(PORT_SEL_TWO, 8'h3c, "master box2");
        io_read(ADDR_FULL_FLAGS, 8'h08, "flags after reads");
        m_u.write_byte(PORT_SEL_FLAGS, 8'hff);
        check("attention off", {7'h00, attn_n}, 8'h01);
        io_read(ADDR_FULL_FLAGS, 8'h00, "flags cleared");
        $display("test outbound finished");
        io_write(ADDR_PORT_CONTROL, 8'h0a);
        m_u.write_byte(PORT_SEL_ZERO, 8'h11);
        m_u.write_byte(PORT_SEL_ONE, 8'h22);
        m_u.write_byte(PORT_SEL_TWO, 8'h33);
        io_read(ADDR_FULL_FLAGS, 8'hf0, "inbound flags");
        check("irq level", {6'h00, irq_level}, 8'h02);
        io_read(ADDR_DATA_ONE, 8'h22, "slave box1");
        io_read(ADDR_FULL_FLAGS, 8'hd0, "box1 emptied");
        io_read(ADDR_DATA_ZERO, 8'h11, "slave box0");
        io_read(ADDR_DATA_TWO, 8'h33, "slave box2");
        io_read(ADDR_FULL_FLAGS, 8'h80, "irq flag stays");
        $display("test inbound finished");
        for (i = 8'h00; i < 8'h10; i++) begin
            io_write(ADDR_PORT_CONTROL, i);
            repeat (2) @(negedge clk);
            check("enable", {7'h00, port_enable}, {7'h00, i[3]});
            check("port a dir", {7'h00, port_a_out},
                  {7'h00, !i[3] && i[2]});
            check("priority", {6'h00, irq_level}, {6'h00, i[1:0]});
        end
        io_write(ADDR_FULL_FLAGS, 8'h00);
        repeat (2) @(negedge clk);
        check("irq cleared", {6'h00, irq_level}, 8'h00);
        io_read(ADDR_FULL_FLAGS, 8'h00, "flags empty");
        io_write(8'h25, 8'hff);
        io_read(8'h25, 8'h00, "unmapped high");
        io_read(8'h1f, 8'h00, "unmapped low");
        $display("test control finished");
        complete_run;
    end
endmodule
